// ===== adp_pkg.sv
// register layout, page codes and decode helpers for the config bank
`default_nettype none
package adp_pkg;
  // bank prefix carried in acc_addr[15:12]
  localparam logic [3:0] ADP_BANK_GEN = 4'h4;
  localparam logic [3:0] ADP_BANK_JESD = 4'h6;
  // general and analog bank offsets
  localparam logic [11:0] ADP_GEN_RESET = 12'h000;
  localparam logic [11:0] ADP_GEN_PAGE_LO = 12'h003;
  localparam logic [11:0] ADP_GEN_PAGE_HI = 12'h004;
  localparam logic [11:0] ADP_GEN_BCAST = 12'h005;
  localparam logic [11:0] ADP_GEN_APAGE = 12'h011;
  localparam logic [11:0] ADP_MST_PDN = 12'h026;
  // page codes
  localparam logic [15:0] ADP_PAGE_MAIN = 16'h6800;
  localparam logic [15:0] ADP_PAGE_LINK = 16'h6900;
  localparam logic [15:0] ADP_PAGE_ANA = 16'h6a00;
  localparam logic [7:0] ADP_APAGE_MASTER = 8'h80;
  localparam logic [7:0] ADP_RST_BYTE = 8'h00;
  localparam logic [15:0] ADP_RST_PAGE = 16'h0000;
  localparam logic [3:0] ADP_DECFIL_LOWPASS = 4'h0;
  // bit positions
  localparam int ADP_COMMIT_BIT = 0;
  localparam int ADP_DECEN_BIT = 3;
  localparam int ADP_DECFIL_HI_BIT = 4;
  localparam int ADP_DECFIL_LO_MSB = 2;
  localparam int ADP_NYQ_BIT = 7;
  localparam int ADP_GAIN_BIT = 0;
  localparam int ADP_DIGRST_BIT = 0;
  localparam int ADP_TXDIS_BIT = 0;
  localparam int ADP_LMODE_MSB = 2;
  localparam int ADP_SCR_BIT = 7;
  localparam int ADP_K_MSB = 4;
  localparam int ADP_PLL_MSB = 1;
  localparam int ADP_SWING_LSB = 5;
  localparam int ADP_BCAST_BIT = 0;
  localparam int ADP_PDN_BIT = 7;
  localparam int ADP_SRST_HI_BIT = 7;
  localparam int ADP_SRST_LO_BIT = 0;

  typedef enum logic [1:0] {ADP_PG_NONE, ADP_PG_MAIN, ADP_PG_LINK,
    ADP_PG_ANA} adp_page_t;
  typedef logic [4:0] adp_slot_t;

  // storage slots; main page slots come first and are committed
  localparam int ADP_NSLOT = 25;
  localparam int ADP_NMAIN = 9;
  localparam adp_slot_t ADP_S_COMMIT = 5'd0;
  localparam adp_slot_t ADP_S_DECFIL = 5'd1;
  localparam adp_slot_t ADP_S_DECEN = 5'd2;
  localparam adp_slot_t ADP_S_NYQ = 5'd3;
  localparam adp_slot_t ADP_S_GAIN = 5'd4;
  localparam adp_slot_t ADP_S_DIGRST = 5'd8;
  localparam adp_slot_t ADP_S_LCTL = 5'd9;
  localparam adp_slot_t ADP_S_LMODE = 5'd10;
  localparam adp_slot_t ADP_S_SCR = 5'd13;
  localparam adp_slot_t ADP_S_KLEN = 5'd14;
  localparam adp_slot_t ADP_S_ORDA = 5'd16;
  localparam adp_slot_t ADP_S_ORDB = 5'd17;
  localparam adp_slot_t ADP_S_PLL = 5'd22;
  localparam adp_slot_t ADP_S_SWING = 5'd24;

  localparam adp_page_t ADP_SLOT_PAGE [ADP_NSLOT] = '{
    ADP_PG_MAIN, ADP_PG_MAIN, ADP_PG_MAIN, ADP_PG_MAIN, ADP_PG_MAIN,
    ADP_PG_MAIN, ADP_PG_MAIN, ADP_PG_MAIN, ADP_PG_MAIN,
    ADP_PG_LINK, ADP_PG_LINK, ADP_PG_LINK, ADP_PG_LINK, ADP_PG_LINK,
    ADP_PG_LINK, ADP_PG_LINK, ADP_PG_LINK, ADP_PG_LINK,
    ADP_PG_ANA, ADP_PG_ANA, ADP_PG_ANA, ADP_PG_ANA, ADP_PG_ANA,
    ADP_PG_ANA, ADP_PG_ANA};
  localparam logic [11:0] ADP_SLOT_OFS [ADP_NSLOT] = '{
    12'h000, 12'h041, 12'h04d, 12'h04e, 12'h052, 12'h072, 12'h0ab,
    12'h0ad, 12'h0f7,
    12'h000, 12'h001, 12'h002, 12'h003, 12'h005, 12'h006, 12'h007,
    12'h031, 12'h032,
    12'h012, 12'h013, 12'h014, 12'h015, 12'h016, 12'h01a, 12'h01b};
  // writable bits; reserved bits store and read as zero
  localparam logic [7:0] ADP_SLOT_MASK [ADP_NSLOT] = '{
    8'h01, 8'h17, 8'h08, 8'h80, 8'h81, 8'h08, 8'h01, 8'h03, 8'h01,
    8'h9f, 8'hc7, 8'he8, 8'hff, 8'h80, 8'h1f, 8'h08, 8'hff, 8'hff,
    8'hfc, 8'hfc, 8'hfc, 8'hfc, 8'h03, 8'h02, 8'he8};

  // map page and offset to {hit, slot}
  function automatic logic [5:0] adp_decode(input adp_page_t pg,
    input logic [11:0] ofs);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < ADP_NSLOT; i++)
    begin
      if (pg == ADP_SLOT_PAGE[i] && ofs == ADP_SLOT_OFS[i])
        r = {1'b1, i[4:0]};
    end
    return r;
  endfunction : adp_decode

  // pick one slot byte out of a packed register image
  function automatic logic [7:0] adp_byte(
    input logic [ADP_NSLOT*8-1:0] v, input adp_slot_t s);
    return v[{s, 3'b000} +: 8];
  endfunction : adp_byte
endpackage : adp_pkg
`default_nettype wire

// ===== adp_chan_regs.sv
// one channel's copy of the jesd bank registers with commit shadow
`default_nettype none
module adp_chan_regs import adp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire adp_page_t page,
  input wire logic [11:0] offset,
  input wire logic [7:0] wdata,
  output logic [ADP_NSLOT*8-1:0] live_q,
  output logic [ADP_NSLOT*8-1:0] eff_q
);
  logic [7:0] mem_reg [ADP_NSLOT];
  logic [7:0] eff_reg [ADP_NMAIN];
  wire logic [5:0] dec;
  wire logic hit;
  wire adp_slot_t slot;
  wire logic commit;

  // slot decode and commit detection on the 1 then 0 write
  assign dec = adp_decode(page, offset);
  assign hit = dec[5];
  assign slot = dec[4:0];
  assign commit = wr_en && hit && slot == ADP_S_COMMIT &&
    !wdata[ADP_COMMIT_BIT] && mem_reg[ADP_S_COMMIT][ADP_COMMIT_BIT];

  // live register storage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      for (int i = 0; i < ADP_NSLOT; i++) mem_reg[i] <= ADP_RST_BYTE;
    else if (wr_en && hit)
      mem_reg[slot] <= wdata & ADP_SLOT_MASK[slot];
  end

  // main page values reach the datapath only on commit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      for (int i = 0; i < ADP_NMAIN; i++) eff_reg[i] <= ADP_RST_BYTE;
    else if (commit)
      for (int i = 0; i < ADP_NMAIN; i++) eff_reg[i] <= mem_reg[i];
  end

  // pack images for the top level
  for (genvar g = 0; g < ADP_NSLOT; g++)
  begin : g_pack
    assign live_q[g*8 +: 8] = mem_reg[g];
    if (g < ADP_NMAIN)
    begin : g_main
      assign eff_q[g*8 +: 8] = eff_reg[g];
    end
    else
    begin : g_rest
      assign eff_q[g*8 +: 8] = mem_reg[g];
    end
  end
endmodule : adp_chan_regs
`default_nettype wire

// ===== adp_config_bank.sv
// register bank for the digital pages of a dual-channel converter
// Notes on behaviour
// - page 68h high, 00h low selects the main digital page 6800h.
// - page 69h high, 00h low selects the link digital page 6900h.
// - analog page offset 016h holds serializer pll mode; 02h means 40x.
// - analog page 80h then C0h to 26h enters global power-down.
// - main offset 041h holds the decimation filter mode; 16h is hp x2.
// - bit 3 of main offset 04Dh lets the filter mode take control.
// - main page values apply after 01h then 00h written to offset 000h.
// - link offsets 031h, 032h hold channel A and B reorder codes.
// - link offset 001h value 01h selects four-lane filter mode.
// - link offset 001h value 02h selects two-lane filter mode.
// - reset gives low-pass filter, lane mode 00h and paired channel writes.
// - page selector splits over address 3 (low) and 4 (high).
// - broadcast-disable 0 writes both channels; 1 uses channel bit.
`default_nettype none
module adp_config_bank import adp_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [15:0] acc_addr,
  input wire logic acc_chan,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  output logic [15:0] link_bank_page_select,
  output logic per_channel_write_enable,
  output logic global_power_down,
  output logic soft_reset,
  output logic [3:0] decimation_filter_select_a,
  output logic [3:0] decimation_filter_select_b,
  output logic nyquist_zone_control_a,
  output logic nyquist_zone_control_b,
  output logic gain_stage_enable_a,
  output logic gain_stage_enable_b,
  output logic digital_block_reset_a,
  output logic digital_block_reset_b,
  output logic transmit_link_disable,
  output logic [2:0] lane_configuration_mode,
  output logic scrambler_enable,
  output logic [4:0] multiframe_frame_count,
  output logic [7:0] channel_a_output_order,
  output logic [7:0] channel_b_output_order,
  output logic [1:0] serializer_pll_mode,
  output logic [2:0] output_swing_select
);
  // general registers
  logic [7:0] page_lo_reg;
  logic [7:0] page_hi_reg;
  logic bcast_dis_reg;
  logic [7:0] apage_reg;
  logic [7:0] mst_pdn_reg;
  logic srst_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  // registered configuration outputs
  logic [3:0] fsel_a_reg;
  logic [3:0] fsel_b_reg;
  logic [7:0] eff_a_nyq_reg;
  logic [7:0] eff_b_nyq_reg;
  logic [7:0] gain_reg;
  logic [7:0] link_reg;
  logic [7:0] lmode_reg;
  logic [7:0] klen_reg;
  logic [7:0] orda_reg;
  logic [7:0] ordb_reg;
  logic [7:0] pll_reg;
  logic [7:0] swing_reg;
  logic [1:0] drst_reg;
  logic scr_reg;

  wire logic int_rst;
  wire logic [3:0] bank;
  wire logic [11:0] ofs;
  wire logic gen_acc;
  wire logic jesd_acc;
  wire logic [15:0] page_now;
  wire adp_page_t page;
  wire logic mst_sel;
  wire logic we_a;
  wire logic we_b;
  wire logic [ADP_NSLOT*8-1:0] live_a;
  wire logic [ADP_NSLOT*8-1:0] live_b;
  wire logic [ADP_NSLOT*8-1:0] eff_a;
  wire logic [ADP_NSLOT*8-1:0] eff_b;
  wire logic [5:0] rd_dec;
  wire logic [7:0] jesd_rd;
  wire logic [7:0] gen_rd;
  wire logic [7:0] rd_next;
  wire logic [3:0] fsel_a_next;
  wire logic [3:0] fsel_b_next;
  // bytes of the effective images used by the output registers
  wire logic [7:0] decen_a_byte;
  wire logic [7:0] decen_b_byte;
  wire logic [7:0] decfil_a_byte;
  wire logic [7:0] decfil_b_byte;
  wire logic [7:0] gain_a_byte;
  wire logic [7:0] gain_b_byte;
  wire logic [7:0] drst_a_byte;
  wire logic [7:0] drst_b_byte;
  wire logic [7:0] lctl_a_byte;
  wire logic [7:0] scr_a_byte;

  // software reset also clears the bank for one cycle, all but the read answer registers
  assign int_rst = sys_rst | srst_reg;

  // address split and page decode
  assign bank = acc_addr[15:12];
  assign ofs = acc_addr[11:0];
  assign gen_acc = bank == ADP_BANK_GEN;
  assign jesd_acc = bank == ADP_BANK_JESD;
  assign page_now = {page_hi_reg, page_lo_reg};
  assign page = page_now == ADP_PAGE_MAIN ? ADP_PG_MAIN :
    page_now == ADP_PAGE_LINK ? ADP_PG_LINK :
    page_now == ADP_PAGE_ANA ? ADP_PG_ANA : ADP_PG_NONE;
  assign mst_sel = apage_reg == ADP_APAGE_MASTER;

  // channel steering for jesd bank writes
  assign we_a = acc_wr && jesd_acc && (!bcast_dis_reg || !acc_chan);
  assign we_b = acc_wr && jesd_acc && (!bcast_dis_reg || acc_chan);

  // page, broadcast, analog page and power-down registers
  always_ff @(posedge clk_sys)
  begin
    if (int_rst)
    begin
      page_lo_reg <= ADP_RST_PAGE[7:0];
      page_hi_reg <= ADP_RST_PAGE[15:8];
      bcast_dis_reg <= 1'b0;
      apage_reg <= ADP_RST_BYTE;
      mst_pdn_reg <= ADP_RST_BYTE;
    end
    else if (acc_wr && gen_acc)
    begin
      if (ofs == ADP_GEN_PAGE_LO)
        page_lo_reg <= acc_wdata;
      if (ofs == ADP_GEN_PAGE_HI)
        page_hi_reg <= acc_wdata;
      if (ofs == ADP_GEN_BCAST)
        bcast_dis_reg <= acc_wdata[ADP_BCAST_BIT];
      if (ofs == ADP_GEN_APAGE)
        apage_reg <= acc_wdata;
      if (ofs == ADP_MST_PDN && mst_sel)
        mst_pdn_reg <= acc_wdata;
    end
  end

  // self-clearing software reset
  always_ff @(posedge clk_sys)
  begin
    if (int_rst)
      srst_reg <= 1'b0;
    else
      srst_reg <= acc_wr && gen_acc && ofs == ADP_GEN_RESET &&
        (acc_wdata[ADP_SRST_HI_BIT] || acc_wdata[ADP_SRST_LO_BIT]);
  end

  // per-channel register copies
  adp_chan_regs u_chan_a (
    .clk_sys(clk_sys),
    .rst(int_rst),
    .wr_en(we_a),
    .page(page),
    .offset(ofs),
    .wdata(acc_wdata),
    .live_q(live_a),
    .eff_q(eff_a)
  );

  adp_chan_regs u_chan_b (
    .clk_sys(clk_sys),
    .rst(int_rst),
    .wr_en(we_b),
    .page(page),
    .offset(ofs),
    .wdata(acc_wdata),
    .live_q(live_b),
    .eff_q(eff_b)
  );

  // read path; paired mode reads back channel A
  assign rd_dec = adp_decode(page, ofs);
  assign jesd_rd = !rd_dec[5] ? ADP_RST_BYTE :
    (bcast_dis_reg && acc_chan) ? adp_byte(live_b, rd_dec[4:0]) :
    adp_byte(live_a, rd_dec[4:0]);
  assign gen_rd = ofs == ADP_GEN_PAGE_LO ? page_lo_reg :
    ofs == ADP_GEN_PAGE_HI ? page_hi_reg :
    ofs == ADP_GEN_BCAST ? {7'h00, bcast_dis_reg} :
    ofs == ADP_GEN_APAGE ? apage_reg :
    (ofs == ADP_MST_PDN && mst_sel) ? mst_pdn_reg : ADP_RST_BYTE;
  assign rd_next = gen_acc ? gen_rd : jesd_acc ? jesd_rd : ADP_RST_BYTE;

  // read answer one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdata_reg <= ADP_RST_BYTE;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= acc_rd;
      if (acc_rd)
        rdata_reg <= rd_next;
    end
  end

  // bytes picked out of the effective images, one named wire each
  assign decen_a_byte = adp_byte(eff_a, ADP_S_DECEN);
  assign decen_b_byte = adp_byte(eff_b, ADP_S_DECEN);
  assign decfil_a_byte = adp_byte(eff_a, ADP_S_DECFIL);
  assign decfil_b_byte = adp_byte(eff_b, ADP_S_DECFIL);
  assign gain_a_byte = adp_byte(eff_a, ADP_S_GAIN);
  assign gain_b_byte = adp_byte(eff_b, ADP_S_GAIN);
  assign drst_a_byte = adp_byte(eff_a, ADP_S_DIGRST);
  assign drst_b_byte = adp_byte(eff_b, ADP_S_DIGRST);
  assign lctl_a_byte = adp_byte(eff_a, ADP_S_LCTL);
  assign scr_a_byte = adp_byte(eff_a, ADP_S_SCR);

  // filter mode counts only while decimation control is enabled
  assign fsel_a_next =
    decen_a_byte[ADP_DECEN_BIT] ?
    {decfil_a_byte[ADP_DECFIL_HI_BIT],
     decfil_a_byte[ADP_DECFIL_LO_MSB:0]}
    : ADP_DECFIL_LOWPASS;
  assign fsel_b_next =
    decen_b_byte[ADP_DECEN_BIT] ?
    {decfil_b_byte[ADP_DECFIL_HI_BIT],
     decfil_b_byte[ADP_DECFIL_LO_MSB:0]}
    : ADP_DECFIL_LOWPASS;

  // output registers follow the effective images
  always_ff @(posedge clk_sys)
  begin
    if (int_rst)
    begin
      fsel_a_reg <= ADP_DECFIL_LOWPASS;
      fsel_b_reg <= ADP_DECFIL_LOWPASS;
      eff_a_nyq_reg <= ADP_RST_BYTE;
      eff_b_nyq_reg <= ADP_RST_BYTE;
      gain_reg <= ADP_RST_BYTE;
      link_reg <= ADP_RST_BYTE;
      lmode_reg <= ADP_RST_BYTE;
      klen_reg <= ADP_RST_BYTE;
      orda_reg <= ADP_RST_BYTE;
      ordb_reg <= ADP_RST_BYTE;
      pll_reg <= ADP_RST_BYTE;
      swing_reg <= ADP_RST_BYTE;
      drst_reg <= 2'b00;
      scr_reg <= 1'b0;
    end
    else
    begin
      fsel_a_reg <= fsel_a_next;
      fsel_b_reg <= fsel_b_next;
      eff_a_nyq_reg <= adp_byte(eff_a, ADP_S_NYQ);
      eff_b_nyq_reg <= adp_byte(eff_b, ADP_S_NYQ);
      gain_reg <= {6'h00,
        gain_b_byte[ADP_GAIN_BIT],
        gain_a_byte[ADP_GAIN_BIT]};
      link_reg <= lctl_a_byte;
      scr_reg <= scr_a_byte[ADP_SCR_BIT]; // kept apart from link control
      lmode_reg <= adp_byte(eff_a, ADP_S_LMODE);
      klen_reg <= adp_byte(eff_a, ADP_S_KLEN);
      orda_reg <= adp_byte(eff_a, ADP_S_ORDA);
      ordb_reg <= adp_byte(eff_b, ADP_S_ORDB);
      pll_reg <= adp_byte(eff_a, ADP_S_PLL);
      swing_reg <= adp_byte(eff_a, ADP_S_SWING);
      drst_reg <= {drst_b_byte[ADP_DIGRST_BIT],
        drst_a_byte[ADP_DIGRST_BIT]};
    end
  end

  // output wiring from registers
  assign acc_rdata = rdata_reg;
  assign acc_rvalid = rvalid_reg;
  assign link_bank_page_select = page_now;
  assign per_channel_write_enable = bcast_dis_reg;
  assign global_power_down = mst_pdn_reg[ADP_PDN_BIT];
  assign soft_reset = srst_reg;
  assign decimation_filter_select_a = fsel_a_reg;
  assign decimation_filter_select_b = fsel_b_reg;
  assign nyquist_zone_control_a = eff_a_nyq_reg[ADP_NYQ_BIT];
  assign nyquist_zone_control_b = eff_b_nyq_reg[ADP_NYQ_BIT];
  assign gain_stage_enable_a = gain_reg[0];
  assign gain_stage_enable_b = gain_reg[1];
  assign digital_block_reset_a = drst_reg[0];
  assign digital_block_reset_b = drst_reg[1];
  assign transmit_link_disable = link_reg[ADP_TXDIS_BIT];
  assign lane_configuration_mode = lmode_reg[ADP_LMODE_MSB:0];
  assign scrambler_enable = scr_reg;
  assign multiframe_frame_count = klen_reg[ADP_K_MSB:0];
  assign channel_a_output_order = orda_reg;
  assign channel_b_output_order = ordb_reg;
  assign serializer_pll_mode = pll_reg[ADP_PLL_MSB:0];
  assign output_swing_select = swing_reg[7:ADP_SWING_LSB];
endmodule : adp_config_bank
`default_nettype wire

// ===== adp_config_bank_props.sv
// port-level assertion checker for the config bank
`default_nettype none
module adp_config_bank_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [15:0] acc_addr,
  input wire logic acc_chan,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic [15:0] link_bank_page_select,
  input wire logic per_channel_write_enable,
  input wire logic global_power_down,
  input wire logic soft_reset,
  input wire logic nyquist_zone_control_a,
  input wire logic [2:0] lane_configuration_mode,
  input wire logic [1:0] serializer_pll_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // write that reaches the channel A copy of a paged register
  sequence wr_at(pg, ad);
    acc_wr && !soft_reset && link_bank_page_select == pg &&
      acc_addr == ad && !(per_channel_write_enable && acc_chan);
  endsequence
  // zero written to the commit bit of the main page
  wire logic commit_wr;
  // write of the power-down bit to 4026h, whichever analog page is selected
  wire logic pdn_wr;
  assign commit_wr = acc_wr && acc_addr == 16'h6000 && !acc_wdata[0] &&
    link_bank_page_select == 16'h6800;
  assign pdn_wr = acc_wr && acc_addr == 16'h4026 && acc_wdata[7];
  // three cycles with no soft reset, and no commit in the middle one
  sequence quiet_main;
    !soft_reset ##1 (!commit_wr && !soft_reset) ##1 !soft_reset;
  endsequence
  chk_read_answer: assert property (
    !soft_reset |=> acc_rvalid == $past(acc_rd))
    else $error("read answer not one cycle after request");
  chk_page_high: assert property (
    acc_wr && !soft_reset && acc_addr == 16'h4004
    |=> link_bank_page_select[15:8] == $past(acc_wdata))
    else $error("page high byte not taken");
  chk_bcast_bit: assert property (
    acc_wr && !soft_reset && acc_addr == 16'h4005
    |=> per_channel_write_enable == $past(acc_wdata[0]))
    else $error("broadcast control not taken");
  chk_lane_mode: assert property (
    wr_at(16'h6900, 16'h6001)
    |-> ##2 lane_configuration_mode == $past(acc_wdata[2:0], 2))
    else $error("lane mode not applied in two cycles");
  chk_pll_mode: assert property (
    wr_at(16'h6a00, 16'h6016)
    |-> ##2 serializer_pll_mode == $past(acc_wdata[1:0], 2))
    else $error("pll mode not applied in two cycles");
  chk_k_upper: assert property (
    acc_rd && !soft_reset && acc_addr == 16'h6006
    |=> acc_rdata[7:5] == 3'h0)
    else $error("frame count upper bits not zero");
  chk_pdn_cause: assert property (
    $rose(global_power_down)
    |-> $past(pdn_wr))
    else $error("power-down rose without its write");
  chk_commit_only: assert property (
    quiet_main |=> $stable(nyquist_zone_control_a))
    else $error("main page output moved without commit");
endmodule : adp_config_bank_props
`default_nettype wire

// ===== adp_host_model.sv
// serial host model driving the bank's register port
`default_nettype none
module adp_host_model (
  input wire logic clk_sys,
  output logic acc_wr,
  output logic acc_rd,
  output logic [15:0] acc_addr,
  output logic acc_chan,
  output logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle port at time zero
  initial
  begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = 16'h0000;
    acc_chan = 1'b0;
    acc_wdata = 8'h00;
  end
  // one access held across a single sampling edge
  task automatic xfer(input logic rd, input logic [15:0] a,
    input logic [7:0] d, input logic ch);
    @(negedge clk_sys);
    acc_rd = rd;
    acc_wr = !rd;
    acc_addr = a;
    acc_wdata = d;
    acc_chan = ch;
    @(negedge clk_sys);
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_addr = ~a; // released address and data lines never hold a stale value
    acc_wdata = ~d;
  endtask : xfer
  // read; the answer is taken one cycle after the request
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    xfer(1'b1, a, 8'h00, 1'b0);
    d = acc_rvalid ? acc_rdata : 8'hxx;
  endtask : rd
  // page select always written as a byte pair, high byte first
  task automatic page(input logic [7:0] hi);
    xfer(1'b0, 16'h4004, hi, 1'b0);
    xfer(1'b0, 16'h4003, 8'h00, 1'b0);
  endtask : page
  // one then zero on the commit bit
  task automatic commit();
    xfer(1'b0, 16'h6000, 8'h01, 1'b0);
    xfer(1'b0, 16'h6000, 8'h00, 1'b0);
  endtask : commit
endmodule : adp_host_model
`default_nettype wire

// ===== tb_adp_config_bank.sv
// self-checking testbench for the config bank
`default_nettype none
module tb_adp_config_bank;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, sys_rst, acc_wr, acc_rd, acc_chan, acc_rvalid;
  logic [15:0] acc_addr, link_bank_page_select;
  logic [7:0] acc_wdata, acc_rdata, channel_a_output_order;
  logic [7:0] channel_b_output_order, r, r2, d;
  logic per_channel_write_enable, global_power_down, soft_reset;
  logic [3:0] decimation_filter_select_a, decimation_filter_select_b;
  logic nyquist_zone_control_a, nyquist_zone_control_b;
  logic gain_stage_enable_a, gain_stage_enable_b;
  logic digital_block_reset_a, digital_block_reset_b;
  logic transmit_link_disable, scrambler_enable;
  logic [2:0] lane_configuration_mode, output_swing_select;
  logic [4:0] multiframe_frame_count;
  logic [1:0] serializer_pll_mode;
  int n_fail, num_checks;
  adp_config_bank DUT (.*);
  adp_host_model h (.*);
  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // expected filter select from the two main page bytes
  function automatic logic [3:0] filt(input logic [7:0] m,
    input logic [7:0] en);
    return en[3] ? {m[4], m[2:0]} : 4'h0;
  endfunction : filt
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic settle();
    repeat (2) @(negedge clk_sys);
  endtask : settle
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the expected run of about a hundred cycles
  initial
  begin
    #20000;
    n_fail++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    void'($urandom(13092));
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    cmp(decimation_filter_select_a, 4'h0);
    cmp(link_bank_page_select, 16'h0000);
    cmp(per_channel_write_enable, 1'b0);
    done("reset");
    h.page(8'h68);
    cmp(link_bank_page_select, 16'h6800);
    h.xfer(1'b0, 16'h6041, 8'h16, 1'b0);
    h.xfer(1'b0, 16'h604d, 8'h08, 1'b0);
    h.xfer(1'b0, 16'h6072, 8'h08, 1'b0);
    h.xfer(1'b0, 16'h6052, 8'h81, 1'b0);
    h.xfer(1'b0, 16'h604e, 8'h80, 1'b0);
    h.xfer(1'b0, 16'h60f7, 8'h01, 1'b0);
    cmp(decimation_filter_select_a, 4'h0);
    cmp(nyquist_zone_control_a, 1'b0);
    h.commit();
    settle();
    cmp(decimation_filter_select_a, filt(8'h16, 8'h08));
    cmp(decimation_filter_select_b, filt(8'h16, 8'h08));
    cmp(nyquist_zone_control_a, 1'b1);
    cmp(gain_stage_enable_a, 1'b1);
    cmp(digital_block_reset_a, 1'b1);
    cmp(nyquist_zone_control_b, 1'b1);
    cmp(gain_stage_enable_b, 1'b1);
    cmp(digital_block_reset_b, 1'b1);
    h.rd(16'h6041, d);
    cmp(d, 8'h16);
    done("main page");
    h.page(8'h69);
    cmp(link_bank_page_select, 16'h6900);
    r = 8'($urandom);
    h.xfer(1'b0, 16'h6031, r, 1'b0);
    h.xfer(1'b0, 16'h6032, 8'h0a, 1'b0);
    h.xfer(1'b0, 16'h6001, 8'h01, 1'b0);
    h.xfer(1'b0, 16'h6000, 8'h81, 1'b0);
    settle();
    cmp(transmit_link_disable, 1'b1);
    cmp(scrambler_enable, 1'b0);
    cmp(channel_a_output_order, r);
    cmp(channel_b_output_order, 8'h0a);
    cmp(lane_configuration_mode, 3'h1);
    h.xfer(1'b0, 16'h6001, 8'h02, 1'b0);
    h.xfer(1'b0, 16'h6005, 8'h80, 1'b0);
    settle();
    cmp(lane_configuration_mode, 3'h2);
    cmp(scrambler_enable, 1'b1);
    repeat (4)
    begin
      r2 = 8'($urandom);
      h.xfer(1'b0, 16'h6006, r2, 1'b0);
      h.rd(16'h6006, d);
      cmp(d, r2 & 8'h1f);
      cmp(multiframe_frame_count, r2[4:0]);
    end
    h.rd(16'h60ff, d);
    cmp(d, 8'h00);
    done("link page");
    h.page(8'h6a);
    h.xfer(1'b0, 16'h6016, 8'h02, 1'b0);
    h.xfer(1'b0, 16'h601b, 8'he0, 1'b0);
    settle();
    cmp(serializer_pll_mode, 2'h2);
    cmp(output_swing_select, 3'h7);
    done("analog page");
    h.xfer(1'b0, 16'h4005, 8'h01, 1'b0);
    cmp(per_channel_write_enable, 1'b1);
    h.page(8'h69);
    r2 = 8'($urandom);
    h.xfer(1'b0, 16'h6032, r2, 1'b1);
    h.xfer(1'b0, 16'h6031, ~r, 1'b1);
    settle();
    cmp(channel_b_output_order, r2);
    cmp(channel_a_output_order, r);
    cmp(link_bank_page_select, 16'h6900);
    done("per channel");
    h.xfer(1'b0, 16'h4026, 8'hc0, 1'b0);
    settle();
    cmp(global_power_down, 1'b0);
    h.xfer(1'b0, 16'h4011, 8'h80, 1'b0);
    h.xfer(1'b0, 16'h4026, 8'hc0, 1'b0);
    settle();
    cmp(global_power_down, 1'b1);
    done("power down");
    h.xfer(1'b0, 16'h4000, 8'h80, 1'b0);
    cmp(soft_reset, 1'b1);
    repeat (3) @(negedge clk_sys);
    cmp(nyquist_zone_control_a, 1'b0);
    cmp(scrambler_enable, 1'b0);
    cmp(link_bank_page_select, 16'h0000);
    cmp(global_power_down, 1'b0);
    cmp(lane_configuration_mode, 3'h0);
    done("soft reset");
    end_of_test();
  end
endmodule : tb_adp_config_bank
bind adp_config_bank adp_config_bank_props u_props (.*);
`default_nettype wire
